/* File: include/osc_select_map.svh */
// Register offsets, field positions, reset values and timing counts of the clock selector
`ifndef OSC_SELECT_MAP_SVH
`define OSC_SELECT_MAP_SVH

// Register byte addresses
`define OSC_TUNING_ADDR     12'h090
`define OSC_CONTROL_ADDR    12'h094
`define OSC_CONFIG_ADDR     12'h098
`define OSC_STATUS_ADDR     12'h09C

// Field positions
`define TUNE_MSB            5
`define FREQ_SEL_MSB        6
`define FREQ_SEL_LSB        4
`define CFG_MODE_MSB        2
`define CFG_PWRT_BIT        3
`define CFG_WDT_BIT         4
`define STAT_SLOW_EN_BIT    0
`define STAT_READY_BIT      1
`define STAT_MODE_LSB       4

// Reset values and frequency select codes
`define TUNE_RST            6'h00
`define FREQ_SEL_RST        3'h0
`define CFG_MODE_RST        3'h6
`define FREQ_SEL_FAST       3'h7
`define FREQ_SEL_SLOW       3'h0

// Timing
`define SYS_CLK_HZ          100000000
`define SYS_PERIOD_NS       10
`define FAST_SRC_HZ         8000000
`define SLOW_SRC_CHZ        3125000
`define FAST_INC            (((64'h1 << 32) * `FAST_SRC_HZ) / `SYS_CLK_HZ)
`define SLOW_INC            (((64'h1 << 32) * `SLOW_SRC_CHZ) / (`SYS_CLK_HZ * 100))
`define FAST_SETTLE_NS      1000000
`define TUNE_STEPS          64
`define FAST_STEP_CYCLES    (`FAST_SETTLE_NS / (`SYS_PERIOD_NS * `TUNE_STEPS))
`define XTAL_START_EDGES    1024
`define CLKOUT_DIV          4

`endif

/* File: include/osc_select_pkg.sv */
// Types shared by the clock selector
package osc_select_pkg;
    // Oscillator modes chosen by the configuration field
    typedef enum logic [2:0] {
        MODE_LOW_POWER_XTAL,
        MODE_CRYSTAL,
        MODE_HIGH_SPEED_XTAL,
        MODE_RC_CLKOUT,
        MODE_RC_IO,
        MODE_INT_CLKOUT,
        MODE_INT_DUAL_IO,
        MODE_EXT_CLOCK_IO
    } clock_mode_t;

    typedef logic signed [5:0] tune_t;
endpackage

/* File: hw/tuned_tick_gen.sv */
// Tunable phase-accumulator tick generator for one internal source
`timescale 1ns/100ps
module tuned_tick_gen #(
    parameter int          ACC_W    = 32,
    parameter logic [31:0] BASE_INC = 32'h0000_0001
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    input  wire logic                  i_run,
    input  wire osc_select_pkg::tune_t i_tune,
    output logic                       o_tick
);
    import osc_select_pkg::*;

    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic             tick_next;
    logic [8:0]       scale;
    logic [40:0]      prod;
    logic [ACC_W:0]   sum;

    ////////////////////////////////////////////////////////////////////////
    // Step is base * (256 + tune) / 256: one code is a constant 1/256 step
    always_comb begin
        scale     = 9'(10'sd256 + 10'(i_tune));
        prod      = {9'h000, BASE_INC} * {32'h0000_0000, scale};
        sum       = {1'b0, acc_reg} + {1'b0, prod[ACC_W+7:8]};
        acc_next  = acc_reg;
        tick_next = 1'b0;
        if (i_run) begin
            acc_next  = sum[ACC_W-1:0];
            tick_next = sum[ACC_W];
        end
    end

    // Accumulator keeps its phase while stopped
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_reg <= '0;
            o_tick  <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            o_tick  <= tick_next;
        end
    end

    a_tick_needs_run: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_tick |-> $past(i_run))
        else $error("tick while source stopped");
endmodule // tuned_tick_gen

/* File: hw/osc_select.sv */
// Clock source selector, internal source postscaler and tuning with APB registers
`timescale 1ns/100ps
`include "osc_select_map.svh"

// Overview of operation
// - Three config bits pick one of eight modes
// - External clock mode: clock in, out pin GPIO6
// - External clock mode: no start-up delay
// - RC mode drives oscillator over four out
// - RC I/O mode: RC clock, out pin GPIO6
// - Fast source 8 MHz, postscaled 125k-4M
// - Slow source runs at 31.25 kHz nominal
// - Slow source on if selected, PWRT, watchdog
// - Frequency select picks direct or postscaled
// - Code 111 fast, 000 slow, else halves
// - Internal clkout mode: Fosc/4 out, GPIO7 in
// - Internal dual I/O: both pins GPIO
// - Tuning shifts both sources, constant step
// - Slow settles in 2 cycles, fast in 1 ms
// - No stall and no shift-done flag
// - Tuning is 6-bit two's complement code
// - Bits 7:6 read zero, reset to zero
// - Tuned slow tick feeds watchdog and peripherals
module osc_select (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_wake,
    input  wire logic        i_osc_in_pin,
    output logic             o_osc_in_pin,
    output logic             o_osc_in_pin_oe_n,
    input  wire logic        i_osc_out_pin,
    output logic             o_osc_out_pin,
    output logic             o_osc_out_pin_oe_n,
    input  wire logic        i_port_a_bit6_out,
    input  wire logic        i_port_a_bit6_drive,
    output logic             o_port_a_bit6_in,
    input  wire logic        i_port_a_bit7_out,
    input  wire logic        i_port_a_bit7_drive,
    output logic             o_port_a_bit7_in,
    output logic             o_sys_tick,
    output logic             o_instr_tick,
    output logic             o_slow_tick,
    output logic             o_slow_src_en,
    output logic             o_clock_ready
);
    import osc_select_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and working signals
    tune_t       tune_reg, tune_next;
    tune_t       tune_fast_reg, tune_fast_next;
    tune_t       tune_slow_reg, tune_slow_next;
    logic [2:0]  freq_sel_reg, freq_sel_next;
    logic [2:0]  cfg_mode_reg, cfg_mode_next;
    logic        cfg_pwrt_reg, cfg_pwrt_next;
    logic        cfg_wdt_reg, cfg_wdt_next;
    logic [31:0] prdata_next;
    logic        pready_next, pslverr_next;
    logic [10:0] step_cnt_reg, step_cnt_next;
    logic [5:0]  post_cnt_reg, post_cnt_next;
    logic [1:0]  div_cnt_reg, div_cnt_next;
    logic [10:0] start_cnt_reg, start_cnt_next;
    logic        ready_next;
    logic        sys_tick_next, instr_tick_next, slow_en_next;
    logic        in_out_next, in_oe_n_next, out_out_next, out_oe_n_next;
    logic        in_s1_reg, in_s2_reg, in_s3_reg, out_s1_reg, out_s2_reg;
    logic        fast_tick, slow_tick, ext_rise, int_tick, slow_run;
    logic        setup, access, rd_hit;
    logic [5:0]  post_mask;
    clock_mode_t mode;
    logic        internal, crystal;

    localparam logic [10:0] STEP_LAST  = 11'(`FAST_STEP_CYCLES - 1);
    localparam logic [10:0] START_LAST = 11'(`XTAL_START_EDGES - 1);

    assign mode     = clock_mode_t'(cfg_mode_reg);
    assign internal = (mode == MODE_INT_CLKOUT) || (mode == MODE_INT_DUAL_IO);
    assign crystal  = (mode == MODE_LOW_POWER_XTAL) || (mode == MODE_CRYSTAL)
                    || (mode == MODE_HIGH_SPEED_XTAL);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the second stage is looked at, and the input pin's third stage only for edge detection
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            in_s1_reg  <= 1'b0;
            in_s2_reg  <= 1'b0;
            in_s3_reg  <= 1'b0;
            out_s1_reg <= 1'b0;
            out_s2_reg <= 1'b0;
        end else begin
            in_s1_reg  <= i_osc_in_pin;
            in_s2_reg  <= in_s1_reg;
            in_s3_reg  <= in_s2_reg;
            out_s1_reg <= i_osc_out_pin;
            out_s2_reg <= out_s1_reg;
        end
    end

    // External and RC clocks arrive on the input pin
    assign ext_rise = in_s2_reg && !in_s3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Internal sources; the slow one must run for PWRT and watchdog too
    assign slow_run = (internal && freq_sel_reg == `FREQ_SEL_SLOW)
                    || cfg_pwrt_reg || cfg_wdt_reg;

    tuned_tick_gen #(.BASE_INC(32'(`FAST_INC))) u_fast_src (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_run     (1'b1),
        .i_tune    (tune_fast_reg),
        .o_tick    (fast_tick)
    );

    tuned_tick_gen #(.BASE_INC(32'(`SLOW_INC))) u_slow_src (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_run     (slow_run),
        .i_tune    (tune_slow_reg),
        .o_tick    (slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source mux: codes 6..1 divide by 2..64, 7 and 0 bypass the postscaler
    always_comb begin
        post_mask     = 6'((7'h01 << (3'h7 - freq_sel_reg)) - 7'h01);
        post_cnt_next = post_cnt_reg + 6'(fast_tick);
        if (freq_sel_reg == `FREQ_SEL_FAST) begin
            int_tick = fast_tick;
        end else if (freq_sel_reg == `FREQ_SEL_SLOW) begin
            int_tick = slow_tick;
        end else begin
            int_tick = fast_tick && ((post_cnt_reg & post_mask) == 6'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tuning: slow source takes the code on its next tick, fast source
    // glides one code per step so a full swing stays inside 1 ms
    always_comb begin
        tune_slow_next = slow_tick ? tune_reg : tune_slow_reg;
        tune_fast_next = tune_fast_reg;
        step_cnt_next  = step_cnt_reg;
        if (tune_fast_reg == tune_reg) begin
            step_cnt_next = 11'h000;
        end else if (step_cnt_reg == STEP_LAST) begin
            step_cnt_next  = 11'h000;
            tune_fast_next = (tune_fast_reg < tune_reg) ? tune_fast_reg + 6'sd1
                                                        : tune_fast_reg - 6'sd1;
        end else begin
            step_cnt_next = step_cnt_reg + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up: after a wake, crystals wait a fixed edge count; other modes run at once
    always_comb begin
        start_cnt_next = start_cnt_reg;
        ready_next     = o_clock_ready;
        if (i_wake || !crystal) begin
            start_cnt_next = 11'h000;
            ready_next     = !crystal;
        end else if (!o_clock_ready && ext_rise) begin
            start_cnt_next = start_cnt_reg + 11'h001;
            ready_next     = (start_cnt_reg == START_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System tick and the divide-by-four instruction clock
    always_comb begin
        sys_tick_next   = o_clock_ready && (internal ? int_tick : ext_rise);
        div_cnt_next    = div_cnt_reg + 2'(o_sys_tick);
        instr_tick_next = o_sys_tick && (div_cnt_reg == 2'(`CLKOUT_DIV - 1));
        slow_en_next    = slow_run;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin roles per mode; enable low means the pin is driven
    always_comb begin
        in_out_next   = 1'b0;
        in_oe_n_next  = 1'b1;
        out_out_next  = 1'b0;
        out_oe_n_next = 1'b1;
        case (mode)
            MODE_RC_CLKOUT: begin
                out_out_next  = div_cnt_reg[1];
                out_oe_n_next = 1'b0;
            end
            MODE_INT_CLKOUT: begin
                out_out_next  = div_cnt_reg[1];
                out_oe_n_next = 1'b0;
                in_out_next   = i_port_a_bit7_out;
                in_oe_n_next  = !i_port_a_bit7_drive;
            end
            MODE_INT_DUAL_IO: begin
                in_out_next   = i_port_a_bit7_out;
                in_oe_n_next  = !i_port_a_bit7_drive;
                out_out_next  = i_port_a_bit6_out;
                out_oe_n_next = !i_port_a_bit6_drive;
            end
            MODE_EXT_CLOCK_IO, MODE_RC_IO: begin
                out_out_next  = i_port_a_bit6_out;
                out_oe_n_next = !i_port_a_bit6_drive;
            end
            default: begin
                // Crystal amplifier is analog and outside this logic
                out_oe_n_next = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: read data is staged in setup, answered in the first access
    // cycle, so every transfer takes exactly one access cycle
    always_comb begin
        setup         = psel && !penable;
        access        = psel && penable && pready;
        rd_hit        = 1'b1;
        prdata_next   = 32'h0000_0000;
        tune_next     = tune_reg;
        freq_sel_next = freq_sel_reg;
        cfg_mode_next = cfg_mode_reg;
        cfg_pwrt_next = cfg_pwrt_reg;
        cfg_wdt_next  = cfg_wdt_reg;
        if (paddr == `OSC_TUNING_ADDR) begin
            prdata_next[`TUNE_MSB:0] = tune_reg;
        end else if (paddr == `OSC_CONTROL_ADDR) begin
            prdata_next[`FREQ_SEL_MSB:`FREQ_SEL_LSB] = freq_sel_reg;
        end else if (paddr == `OSC_CONFIG_ADDR) begin
            prdata_next[`CFG_MODE_MSB:0] = cfg_mode_reg;
            prdata_next[`CFG_PWRT_BIT]   = cfg_pwrt_reg;
            prdata_next[`CFG_WDT_BIT]    = cfg_wdt_reg;
        end else if (paddr == `OSC_STATUS_ADDR) begin
            prdata_next[`STAT_SLOW_EN_BIT]           = o_slow_src_en;
            prdata_next[`STAT_READY_BIT]             = o_clock_ready;
            prdata_next[`STAT_MODE_LSB+2:`STAT_MODE_LSB] = cfg_mode_reg;
        end else begin
            rd_hit = 1'b0;
        end
        if (access && pwrite) begin
            if (paddr == `OSC_TUNING_ADDR) begin
                tune_next = tune_t'(pwdata[`TUNE_MSB:0]);
            end else if (paddr == `OSC_CONTROL_ADDR) begin
                freq_sel_next = pwdata[`FREQ_SEL_MSB:`FREQ_SEL_LSB];
            end else if (paddr == `OSC_CONFIG_ADDR) begin
                cfg_mode_next = pwdata[`CFG_MODE_MSB:0];
                cfg_pwrt_next = pwdata[`CFG_PWRT_BIT];
                cfg_wdt_next  = pwdata[`CFG_WDT_BIT];
            end
        end
        pready_next  = setup;
        pslverr_next = setup && !rd_hit;
        if (!setup) begin
            prdata_next = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; tuning and its applied copies reset to centre
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            tune_reg           <= `TUNE_RST;
            tune_fast_reg      <= `TUNE_RST;
            tune_slow_reg      <= `TUNE_RST;
            freq_sel_reg       <= `FREQ_SEL_RST;
            cfg_mode_reg       <= `CFG_MODE_RST;
            cfg_pwrt_reg       <= 1'b0;
            cfg_wdt_reg        <= 1'b0;
            step_cnt_reg       <= 11'h000;
            post_cnt_reg       <= 6'h00;
            div_cnt_reg        <= 2'h0;
            start_cnt_reg      <= 11'h000;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            o_clock_ready      <= 1'b0;
            o_sys_tick         <= 1'b0;
            o_instr_tick       <= 1'b0;
            o_slow_tick        <= 1'b0;
            o_slow_src_en      <= 1'b0;
            o_osc_in_pin       <= 1'b0;
            o_osc_in_pin_oe_n  <= 1'b1;
            o_osc_out_pin      <= 1'b0;
            o_osc_out_pin_oe_n <= 1'b1;
            o_port_a_bit6_in   <= 1'b0;
            o_port_a_bit7_in   <= 1'b0;
        end else begin
            tune_reg           <= tune_next;
            tune_fast_reg      <= tune_fast_next;
            tune_slow_reg      <= tune_slow_next;
            freq_sel_reg       <= freq_sel_next;
            cfg_mode_reg       <= cfg_mode_next;
            cfg_pwrt_reg       <= cfg_pwrt_next;
            cfg_wdt_reg        <= cfg_wdt_next;
            step_cnt_reg       <= step_cnt_next;
            post_cnt_reg       <= post_cnt_next;
            div_cnt_reg        <= div_cnt_next;
            start_cnt_reg      <= start_cnt_next;
            prdata             <= prdata_next;
            pready             <= pready_next;
            pslverr            <= pslverr_next;
            o_clock_ready      <= ready_next;
            o_sys_tick         <= sys_tick_next;
            o_instr_tick       <= instr_tick_next;
            o_slow_tick        <= slow_tick;
            o_slow_src_en      <= slow_en_next;
            o_osc_in_pin       <= in_out_next;
            o_osc_in_pin_oe_n  <= in_oe_n_next;
            o_osc_out_pin      <= out_out_next;
            o_osc_out_pin_oe_n <= out_oe_n_next;
            o_port_a_bit6_in   <= out_s2_reg;
            o_port_a_bit7_in   <= in_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_tune_readback: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (setup && !pwrite && paddr == `OSC_TUNING_ADDR)
        |=> (prdata[31:6] == 26'h0 && prdata[5:0] == $past(tune_reg)))
        else $error("tuning read data wrong");
    a_rc_clkout_drive: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $past(mode == MODE_RC_CLKOUT) |-> (!o_osc_out_pin_oe_n
        && o_osc_out_pin == $past(div_cnt_reg[1])))
        else $error("RC clock out not driven");
    a_external_clock_io_mode_gpio6: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $past(mode == MODE_EXT_CLOCK_IO) |-> (o_osc_out_pin_oe_n
        == !$past(i_port_a_bit6_drive) && o_osc_out_pin == $past(i_port_a_bit6_out)))
        else $error("out pin not handed to port bit 6");
    a_external_clock_io_mode_no_delay: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (mode == MODE_EXT_CLOCK_IO) [*2] |-> o_clock_ready)
        else $error("start-up delay in external clock mode");
    a_slow_for_wdt: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        cfg_wdt_reg |=> o_slow_src_en)
        else $error("slow source off with watchdog on");
    a_slow_tune_apply: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        slow_tick |=> (tune_slow_reg == $past(tune_reg)))
        else $error("slow source missed new tuning");
    a_fast_glide_step: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (tune_fast_reg < tune_reg && step_cnt_reg == STEP_LAST)
        |=> (tune_fast_reg == $past(tune_fast_reg) + 6'sd1))
        else $error("fast tuning glide stalled");
    a_instr_div4: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_instr_tick |-> ($past(o_sys_tick) && $past(div_cnt_reg) == 2'h3))
        else $error("instruction tick not every fourth");
    a_post_div2: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (internal && freq_sel_reg == 3'h6 && int_tick) |-> (post_cnt_reg[0] == 1'b0))
        else $error("postscaler ratio wrong");
endmodule // osc_select

/* File: bench/test_osc_select.sv */
// Self-checking bench for the clock source selector and its APB registers
`timescale 1ns/100ps
`include "osc_select_map.svh"
module test_osc_select;
    logic        i_clk_sys, i_nrst, psel, penable, pwrite, pready, pslverr, i_wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pin_in, in_d, in_oe_n, pin_out, out_d, out_oe_n, ext_run, err;
    logic        ext_clk = 1'b0;
    logic        b6_out, b6_drv, b6_in, b7_out, b7_drv, b7_in;
    logic        sys_tick, instr_tick, slow_tick, slow_en, ready;
    int          bad_count, checks_done, ns, ni, no;

    // Wire levels: the design wins when it drives; a released out pin shows the
    // inverse of its last value, so a stale sample cannot pass unnoticed
    assign pin_in  = !in_oe_n ? in_d : ext_clk;
    assign pin_out = !out_oe_n ? out_d : !out_d;

    osc_select i_osc_select (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_wake(i_wake), .i_osc_in_pin(pin_in),
        .o_osc_in_pin(in_d), .o_osc_in_pin_oe_n(in_oe_n), .i_osc_out_pin(pin_out),
        .o_osc_out_pin(out_d), .o_osc_out_pin_oe_n(out_oe_n), .i_port_a_bit6_out(b6_out),
        .i_port_a_bit6_drive(b6_drv), .o_port_a_bit6_in(b6_in), .i_port_a_bit7_out(b7_out),
        .i_port_a_bit7_drive(b7_drv), .o_port_a_bit7_in(b7_in), .o_sys_tick(sys_tick),
        .o_instr_tick(instr_tick), .o_slow_tick(slow_tick), .o_slow_src_en(slow_en),
        .o_clock_ready(ready));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, external clock source and watchdog
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // External source runs at one tenth of the system clock, only when asked
    always @(posedge i_clk_sys) begin
        if (ext_run) begin
            repeat (4) @(posedge i_clk_sys);
            ext_clk <= ~ext_clk;
        end
    end
    // Tests need about 72000 cycles; the limit leaves some margin
    initial begin
        #900000;
        bad_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge; one idle edge
    // follows so a next call never reassigns psel in the same step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    // Counts ticks and rising edges of the out pin over a span
    task automatic count(input int cyc);
        logic last;
        ns = 0;
        ni = 0;
        no = 0;
        last = pin_out;
        repeat (cyc) begin
            @(posedge i_clk_sys);
            ns += (sys_tick === 1'b1);
            ni += (instr_tick === 1'b1);
            no += (pin_out === 1'b1 && last === 1'b0);
            last = pin_out;
        end
    endtask
    function automatic logic [31:0] near(input int seen, input int exp);
        return (seen >= exp - 1 && seen <= exp + 1) ? 32'h1 : 32'h0;
    endfunction
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_nrst, psel, penable, pwrite, i_wake, ext_run} = 6'h00;
        {b6_out, b6_drv, b7_out, b7_drv} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        bad_count = 0;
        checks_done = 0;
        repeat (2) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        // Reset values, then an unmapped place
        apb(1'b0, `OSC_TUNING_ADDR, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, `OSC_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0000_0063);
        apb(1'b0, 12'h0A0, 32'h0);
        chk({rd[31:1], err}, 32'h0000_0001);
        // Frequency codes 7 to 1: direct fast source, then halving postscaler
        for (int c = 7; c >= 1; c--) begin
            apb(1'b1, `OSC_CONTROL_ADDR, 32'(c) << 4);
            repeat (20) @(posedge i_clk_sys);
            count(3200);
            chk(near(ns, 256 >> (7 - c)), 32'h1);
            chk(near(ni, 64 >> (7 - c)), 32'h1);
        end
        // Back to the direct fast source for the tests that follow
        apb(1'b1, `OSC_CONTROL_ADDR, 32'h0000_0070);
        chk(slow_en, 1'b0);
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0016);
        repeat (2) @(posedge i_clk_sys);
        chk(slow_en, 1'b1);
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_000E);
        repeat (2) @(posedge i_clk_sys);
        chk(slow_en, 1'b1);
        // Dual I/O: both pins follow the port bits, both ways
        b6_drv <= 1'b1;
        b6_out <= 1'b1;
        b7_drv <= 1'b1;
        b7_out <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        chk({out_oe_n, out_d, in_oe_n, in_d, b6_in, b7_in}, 6'b010111);
        // Clock-out mode: pin carries a quarter of the system rate, bit 7 stays a port
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0005);
        count(3200);
        chk({out_oe_n, in_oe_n}, 2'b00);
        chk(near(no, 64), 32'h1);
        // Tuning: upper bits read zero, then a positive code speeds the fast source
        apb(1'b1, `OSC_TUNING_ADDR, 32'h0000_00FF);
        apb(1'b0, `OSC_TUNING_ADDR, 32'h0);
        chk(rd, 32'h0000_003F);
        apb(1'b1, `OSC_TUNING_ADDR, 32'h0000_0008);
        repeat (16000) @(posedge i_clk_sys);
        count(3200);
        chk(near(ns, 264), 32'h1);
        // Slow source as system clock: first tick takes the code, next period is tuned
        apb(1'b1, `OSC_CONTROL_ADDR, 32'h0000_0000);
        do begin
            @(posedge i_clk_sys);
        end while (slow_tick !== 1'b1);
        ns = 0;
        ni = 0;
        do begin
            @(posedge i_clk_sys);
            ns++;
            ni += (sys_tick === 1'b1);
        end while (slow_tick !== 1'b1);
        chk(near(ns, 3103), 32'h1);
        chk(ni, 32'h1);
        chk(slow_en, 1'b1);
        // External clock: pin edges drive the clock, no start-up wait, pin 6 a port
        ext_run <= 1'b1;
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0007);
        repeat (2) @(posedge i_clk_sys);
        chk(ready, 1'b1);
        i_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_wake <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk(ready, 1'b1);
        count(3200);
        chk(near(ns, 320), 32'h1);
        chk({out_oe_n, out_d}, 2'b01);
        // RC with clock out, then RC with the out pin as a port
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0003);
        count(3200);
        chk(near(no, 80), 32'h1);
        chk(out_oe_n, 1'b0);
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0004);
        b6_drv <= 1'b0;
        count(3200);
        chk(near(ns, 320), 32'h1);
        chk(out_oe_n, 1'b1);
        apb(1'b0, `OSC_STATUS_ADDR, 32'h0);
        chk(rd[6:4], 3'h4);
        // Crystal: a wake restarts the edge count, ready only after the full count
        apb(1'b1, `OSC_CONFIG_ADDR, 32'h0000_0001);
        i_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_wake <= 1'b0;
        repeat (10100) @(posedge i_clk_sys);
        chk(ready, 1'b0);
        repeat (300) @(posedge i_clk_sys);
        chk(ready, 1'b1);
        test_done();
    end
endmodule // test_osc_select
